//--- pkg/ledp_map.svh
// Register offsets, reset values and timing counts of the LED/GPIO block
`ifndef LEDP_MAP_SVH
`define LEDP_MAP_SVH

`define LEDP_OFS_DIR        8'h70
`define LEDP_OFS_OTYPE      8'h71
`define LEDP_OFS_PIN_STATE  8'h72
`define LEDP_OFS_DRIVE_1    8'h73
`define LEDP_OFS_DRIVE_2    8'h74
`define LEDP_OFS_POL_1      8'h75
`define LEDP_OFS_POL_2      8'h76
`define LEDP_OFS_MIRROR_1   8'h79
`define LEDP_OFS_MIRROR_2   8'h7A

`define LEDP_RST_REG        8'h00
`define LEDP_HI_MASK        8'h07
`define LEDP_NO_LINK_MASK   11'h480
`define LEDP_FULL_PCT       7'h64

`define LEDP_CLK_NS         20
`define LEDP_STEP_NS        2000
`define LEDP_STEP_CYC       (`LEDP_STEP_NS / `LEDP_CLK_NS)

`endif

//--- pkg/ledp_pkg.sv
// Types shared by the LED/GPIO output polarity block
package ledp_pkg;
  typedef logic [10:0] ledp_chan_t;
  typedef logic [7:0]  ledp_gpio_t;
  typedef logic [6:0]  ledp_pct_t;
  typedef logic [7:0]  ledp_byte_t;
endpackage

//--- design/ledp_duty_map.sv
// Maps min/max duty and mirror setting of one LED channel onto the PWM pin level
`timescale 1ns/100ps
`include "ledp_map.svh"
module ledp_duty_map (
  // Channel configuration
  input  wire logic             drive_i,
  input  wire logic             mirror_i,
  input  wire logic             breathe_i,
  // Duty settings and PWM position
  input  wire ledp_pkg::ledp_pct_t min_duty_i,
  input  wire ledp_pkg::ledp_pct_t max_duty_i,
  input  wire ledp_pkg::ledp_pct_t ramp_i,
  input  wire ledp_pkg::ledp_pct_t phase_i,
  // Result
  output logic                  pin_low_o
);
  import ledp_pkg::*;

  ledp_pct_t sel_duty;
  ledp_pct_t on_share;

  always_comb begin
    // Drive 0 sits at minimum; breathe ramps min to max; direct is max
    if (!drive_i) begin
      sel_duty = min_duty_i;
    end else if (breathe_i) begin
      sel_duty = ramp_i;
    end else begin
      sel_duty = max_duty_i;
    end
    // Mirrored settings count from 100 instead of 0
    if (mirror_i) begin
      on_share = `LEDP_FULL_PCT - sel_duty;
    end else begin
      on_share = sel_duty;
    end
    pin_low_o = (phase_i < on_share);
  end
endmodule

//--- design/ledp_gpio_port.sv
// Shared LED/GPIO pin control: input sampling, drive, polarity, duty mapping
`timescale 1ns/100ps
`include "ledp_map.svh"
// How it works
// - Input register follows every pin level
// - Input pins set change flag on change
// - Enabled set change flag raises interrupt
// - Drive bits act only on output pins
// - Polarity sets the non-actuated pin state
// - Drive 0 min/idle, drive 1 max/actuated
// - Channels 8 and 11 never touch-linked
// - Linking channel 10 also links channel 9
// - Polarity writes copy into mirror bits unless blocked
// - Linked touch acts as drive bit one
// - Inverted: duty is pin low share
// - Inverted: idle at min, breathe min to max
// - Non-inverted: duty is pin high share
// - Non-inverted: idle and breathe relative to 100
// - Non-inverted direct gives 100 minus max
// - Mirror affects brightness, never direct pin level
// - Direction 0 input, 1 output
// - Type 0 open-drain, 1 push-pull
// - Polarity 0 inverts drive, 1 passes it
module ledp_gpio_port #(
  parameter int STEP_CYC = `LEDP_STEP_CYC
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                arst_n_i,
  // Register port
  input  wire ledp_pkg::ledp_byte_t reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire ledp_pkg::ledp_byte_t reg_wdata_i,
  output ledp_pkg::ledp_byte_t     reg_rdata_o,
  // Configuration outside this register map
  input  wire logic                mirror_follow_block_i,
  input  wire ledp_pkg::ledp_gpio_t irq_en_i,
  input  wire ledp_pkg::ledp_gpio_t pin_change_clr_i,
  input  wire ledp_pkg::ledp_chan_t pwm_en_i,
  input  wire ledp_pkg::ledp_chan_t breathe_i,
  input  wire ledp_pkg::ledp_pct_t  min_duty_i,
  input  wire ledp_pkg::ledp_pct_t  max_duty_i,
  input  wire ledp_pkg::ledp_pct_t  ramp_i,
  // Touch linking
  input  wire ledp_pkg::ledp_chan_t link_i,
  input  wire ledp_pkg::ledp_chan_t touch_i,
  // Status
  output ledp_pkg::ledp_gpio_t     pin_change_flag_o,
  output logic                     irq_o,
  // Pins
  input  wire ledp_pkg::ledp_gpio_t pin_in_i,
  output ledp_pkg::ledp_chan_t     led_pin_o,
  output ledp_pkg::ledp_chan_t     led_pin_oe_n_o
);
  import ledp_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers and change detection
  // ---------------------------------------------------------------
  ledp_gpio_t sync_a;
  ledp_gpio_t dir;
  ledp_gpio_t pin_input_state;
  ledp_gpio_t pin_prev;
  ledp_gpio_t flag;
  ledp_gpio_t next_flag;
  ledp_gpio_t pin_edge;

  always_comb begin
    pin_edge  = pin_input_state ^ pin_prev;
    next_flag = (flag & ~pin_change_clr_i) | (pin_edge & ~dir);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_a          <= `LEDP_RST_REG;
      pin_input_state <= `LEDP_RST_REG;
      pin_prev        <= `LEDP_RST_REG;
      flag            <= `LEDP_RST_REG;
    end else begin
      sync_a          <= pin_in_i;
      pin_input_state <= sync_a;
      pin_prev        <= pin_input_state;
      flag            <= next_flag;
    end
  end

  assign pin_change_flag_o = flag;
  assign irq_o             = |(flag & irq_en_i);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  ledp_gpio_t otype;
  ledp_chan_t drive;
  ledp_chan_t pol;
  ledp_chan_t mir;
  ledp_byte_t rdata;
  ledp_gpio_t next_dir;
  ledp_gpio_t next_otype;
  ledp_chan_t next_drive;
  ledp_chan_t next_pol;
  ledp_chan_t next_mir;
  ledp_byte_t next_rdata;
  ledp_chan_t wr_pol;

  function automatic ledp_byte_t hi_byte(input logic [2:0] bits);
    hi_byte = {5'h00, bits} & `LEDP_HI_MASK;
  endfunction

  always_comb begin
    next_dir   = dir;
    next_otype = otype;
    next_drive = drive;
    next_pol   = pol;
    next_mir   = mir;
    next_rdata = rdata;
    wr_pol     = pol;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LEDP_OFS_DIR:      next_dir          = reg_wdata_i;
        `LEDP_OFS_OTYPE:    next_otype        = reg_wdata_i;
        `LEDP_OFS_DRIVE_1:  next_drive[7:0]   = reg_wdata_i;
        `LEDP_OFS_DRIVE_2:  next_drive[10:8]  = reg_wdata_i[2:0];
        `LEDP_OFS_POL_1:    wr_pol[7:0]       = reg_wdata_i;
        `LEDP_OFS_POL_2:    wr_pol[10:8]      = reg_wdata_i[2:0];
        `LEDP_OFS_MIRROR_1: next_mir[7:0]     = reg_wdata_i;
        `LEDP_OFS_MIRROR_2: next_mir[10:8]    = reg_wdata_i[2:0];
        default: begin
        end
      endcase
      next_pol = wr_pol;
      if (!mirror_follow_block_i) begin
        next_mir = (next_mir & ~(wr_pol ^ pol)) | (wr_pol & (wr_pol ^ pol));
      end
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LEDP_OFS_DIR:       next_rdata = dir;
        `LEDP_OFS_OTYPE:     next_rdata = otype;
        `LEDP_OFS_PIN_STATE: next_rdata = pin_input_state;
        `LEDP_OFS_DRIVE_1:   next_rdata = drive[7:0];
        `LEDP_OFS_DRIVE_2:   next_rdata = hi_byte(drive[10:8]);
        `LEDP_OFS_POL_1:     next_rdata = pol[7:0];
        `LEDP_OFS_POL_2:     next_rdata = hi_byte(pol[10:8]);
        `LEDP_OFS_MIRROR_1:  next_rdata = mir[7:0];
        `LEDP_OFS_MIRROR_2:  next_rdata = hi_byte(mir[10:8]);
        default:             next_rdata = `LEDP_RST_REG;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir   <= `LEDP_RST_REG;
      otype <= `LEDP_RST_REG;
      drive <= 11'h000;
      pol   <= 11'h000;
      mir   <= 11'h000;
      rdata <= `LEDP_RST_REG;
    end else begin
      dir   <= next_dir;
      otype <= next_otype;
      drive <= next_drive;
      pol   <= next_pol;
      mir   <= next_mir;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // ---------------------------------------------------------------
  // PWM step divider and phase counter (0..99)
  // ---------------------------------------------------------------
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  ledp_pct_t   phase;
  ledp_pct_t   next_phase;
  logic        step_en;

  always_comb begin
    step_en      = (div_cnt == 16'(STEP_CYC - 1));
    next_div_cnt = step_en ? 16'h0000 : div_cnt + 16'h0001;
    next_phase   = phase;
    if (step_en) begin
      next_phase = (phase == `LEDP_FULL_PCT - 7'h01) ? 7'h00 : phase + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 16'h0000;
      phase   <= 7'h00;
    end else begin
      div_cnt <= next_div_cnt;
      phase   <= next_phase;
    end
  end

  // ---------------------------------------------------------------
  // Effective drive and pin shaping
  // ---------------------------------------------------------------
  ledp_chan_t link_eff;
  ledp_chan_t eff_drive;
  ledp_chan_t pwm_low;
  ledp_chan_t out_en;
  ledp_chan_t push_pull;
  ledp_chan_t level;
  ledp_chan_t next_pin;
  ledp_chan_t next_oe_n;
  ledp_chan_t pin_q;
  ledp_chan_t oe_n_q;

  for (genvar ch = 0; ch < 11; ch++) begin : g_duty
    ledp_duty_map u_duty (
      .drive_i    (eff_drive[ch]),
      .mirror_i   (mir[ch]),
      .breathe_i  (breathe_i[ch]),
      .min_duty_i (min_duty_i),
      .max_duty_i (max_duty_i),
      .ramp_i     (ramp_i),
      .phase_i    (phase),
      .pin_low_o  (pwm_low[ch])
    );
  end

  always_comb begin
    link_eff    = link_i & ~`LEDP_NO_LINK_MASK;
    link_eff[8] = link_i[8] | link_i[9];
    eff_drive   = drive | (link_eff & touch_i);
    out_en      = {3'b111, dir};
    push_pull   = {3'b000, otype};
    for (int i = 0; i < 11; i++) begin
      if (pwm_en_i[i]) begin
        level[i] = ~pwm_low[i];
      end else begin
        level[i] = pol[i] ? eff_drive[i] : ~eff_drive[i];
      end
      if (!out_en[i]) begin
        next_pin[i]  = 1'b0;
        next_oe_n[i] = 1'b1;
      end else if (push_pull[i]) begin
        next_pin[i]  = level[i];
        next_oe_n[i] = 1'b0;
      end else begin
        next_pin[i]  = 1'b0;
        next_oe_n[i] = level[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q  <= 11'h000;
      oe_n_q <= 11'h7FF;
    end else begin
      pin_q  <= next_pin;
      oe_n_q <= next_oe_n;
    end
  end

  assign led_pin_o      = pin_q;
  assign led_pin_oe_n_o = oe_n_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_input_follow: assert property (
    $stable(pin_in_i) [*3] |-> pin_input_state == pin_in_i)
    else $error("input register does not follow pins");

  chk_flag_set: assert property (
    (pin_edge[0] && !dir[0]) |=> flag[0])
    else $error("change flag not set on input pin change");

  chk_flag_output_pin: assert property (
    (pin_edge[0] && dir[0] && !flag[0]) |=> !flag[0])
    else $error("change flag set on output pin");

  chk_irq_raise: assert property (
    (flag[0] && irq_en_i[0]) |-> irq_o)
    else $error("interrupt missing for enabled flag");

  chk_input_no_drive: assert property (
    !dir[0] |=> led_pin_oe_n_o[0])
    else $error("input pin is driven");

  chk_no_link_ch8: assert property (
    (!drive[7] && link_i[7] && touch_i[7]) |-> !eff_drive[7])
    else $error("channel 8 followed a touch");

  chk_group_link: assert property (
    (link_i[9] && touch_i[8]) |-> eff_drive[8])
    else $error("channel 9 not linked with channel 10");

  chk_mirror_copy: assert property (
    (reg_wr_i && reg_addr_i == 8'h75 && !mirror_follow_block_i)
      |=> ((mir[7:0] ^ $past(mir[7:0])) & ~($past(pol[7:0])
           ^ $past(reg_wdata_i))) == 8'h00 &&
          (mir[7:0] & (pol[7:0] ^ $past(pol[7:0])))
           == (pol[7:0] & (pol[7:0] ^ $past(pol[7:0]))))
    else $error("mirror bits did not track polarity write");

  chk_polarity_drive: assert property (
    (dir[0] && otype[0] && !pwm_en_i[0])
      |=> led_pin_o[0] == ($past(pol[0]) ~^ $past(eff_drive[0])))
    else $error("push-pull level disagrees with polarity");

  chk_high_read_zero: assert property (
    (reg_rd_i && reg_addr_i == 8'h74) |=> reg_rdata_o[7:3] == 5'h00)
    else $error("unused drive bits read non-zero");

  chk_duty_idle: assert property (
    (pwm_en_i[8] && !mir[8] && !eff_drive[8])
      |=> led_pin_oe_n_o[8] == ($past(phase) >= $past(min_duty_i)))
    else $error("idle duty low time differs from minimum");

  cov_input_change: cover property (pin_edge[0] && !dir[0] ##1 irq_o);
  cov_open_drain_low: cover property (dir[1] && !otype[1] ##1
                                      !led_pin_oe_n_o[1]);
  cov_pol_mirror: cover property (reg_wr_i && reg_addr_i == 8'h76
                                  ##1 mir[10]);
  cov_touch_link: cover property (link_i[0] && touch_i[0] && !drive[0]);
endmodule

//--- testbench/ledp_pin_model.sv
// Pin-side model: LEDs, pull-ups and external logic on the shared pins
`timescale 1ns/100ps
module ledp_pin_model (
  // Design pin side
  input  wire ledp_pkg::ledp_chan_t pin_i,
  input  wire ledp_pkg::ledp_chan_t oe_n_i,
  // External logic on GPIO pins
  input  wire ledp_pkg::ledp_gpio_t ext_en_i,
  input  wire ledp_pkg::ledp_gpio_t ext_val_i,
  // Resolved pad levels
  output ledp_pkg::ledp_chan_t     pad_o
);
  import ledp_pkg::*;
  ledp_chan_t en_w;
  ledp_chan_t val_w;
  assign en_w  = {3'h0, ext_en_i};
  assign val_w = {3'h0, ext_val_i};
  // Driving pin wins, then external logic, else the pull-up
  assign pad_o = (~oe_n_i & pin_i)
               | (oe_n_i & ((en_w & val_w) | ~en_w));
endmodule

//--- testbench/ledp_gpio_port_tb_top.sv
// Self-checking bench for the LED/GPIO output polarity block
`timescale 1ns/100ps
module ledp_gpio_port_tb_top;
  import ledp_pkg::*;
  logic       clk, rst_n, wr, rd, blk, irq;
  ledp_byte_t addr, wdata, rdata, rv;
  ledp_gpio_t irq_en, clr, flag, ext_en, ext_val;
  ledp_chan_t pwm_en, brth, link, touch, pin, oe_n, pad;
  ledp_pct_t  min_d, max_d, ramp;
  int         error_cnt, check_count, cyc, n;

  ledp_gpio_port #(.STEP_CYC(2)) ledp_gpio_port_i (
    .core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .mirror_follow_block_i(blk),
    .irq_en_i(irq_en), .pin_change_clr_i(clr), .pwm_en_i(pwm_en),
    .breathe_i(brth), .min_duty_i(min_d), .max_duty_i(max_d),
    .ramp_i(ramp), .link_i(link), .touch_i(touch),
    .pin_change_flag_o(flag), .irq_o(irq), .pin_in_i(pad[7:0]),
    .led_pin_o(pin), .led_pin_oe_n_o(oe_n));
  ledp_pin_model ledp_pin_model_i (
    .pin_i(pin), .oe_n_i(oe_n), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_o(pad));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr_reg(input ledp_byte_t a, input ledp_byte_t d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input ledp_byte_t a, output ledp_byte_t d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Reset values, read-only and unused bits
  task automatic t_regs();
    for (int a = 8'h72; a <= 8'h76; a++) begin
      rd_reg(a[7:0], rv);
      chk("reset value", 11'h000, {3'h0, rv});
    end
    wr_reg(8'h72, 8'hFF);
    rd_reg(8'h72, rv);
    chk("input reg write", 11'h000, {3'h0, rv});
    wr_reg(8'h74, 8'hFF);
    rd_reg(8'h74, rv);
    chk("drive2 high bits", 11'h007, {3'h0, rv});
    wr_reg(8'h76, 8'hFF);
    rd_reg(8'h76, rv);
    chk("pol2 high bits", 11'h007, {3'h0, rv});
    wr_reg(8'h74, 8'h00);
    wr_reg(8'h76, 8'h00);
  endtask

  // Input sampling, change flag and interrupt
  task automatic t_input();
    irq_en = 8'h01;
    ext_val = 8'h01;
    settle(3);
    chk("flag", 11'h001, {3'h0, flag});
    chk("irq", 11'h001, {10'h0, irq});
    rd_reg(8'h72, rv);
    chk("input state", 11'h001, {3'h0, rv});
    irq_en = 8'h00;
    settle(1);
    chk("irq masked", 11'h000, {10'h0, irq});
    clr = 8'h01;
    settle(1);
    clr = 8'h00;
    settle(1);
    chk("flag cleared", 11'h000, {3'h0, flag});
    wr_reg(8'h70, 8'h01);
    wr_reg(8'h71, 8'h01);
    wr_reg(8'h75, 8'h01);
    ext_en = 8'hFE;
    wr_reg(8'h73, 8'h00);
    settle(4);
    rd_reg(8'h72, rv);
    chk("output pin state", 11'h000, {3'h0, rv});
    chk("output no flag", 11'h000, {3'h0, flag});
  endtask

  // Drive, type, polarity and direction of channel 1
  task automatic t_drive();
    logic lv;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h71, {7'h0, i[2]});
      wr_reg(8'h75, {7'h0, i[1]});
      wr_reg(8'h73, {7'h0, i[0]});
      settle(2);
      lv = i[1] ? i[0] : ~i[0];
      chk("oe_n,pin", i[2] ? {9'h0, 1'b0, lv} : {9'h0, lv, 1'b0},
          {9'h0, oe_n[0], pin[0]});
    end
    wr_reg(8'h70, 8'h00);
    settle(2);
    chk("input dir oe_n", 11'h001, {10'h0, oe_n[0]});
    wr_reg(8'h70, 8'h01);
    wr_reg(8'h73, 8'h00);
    link = 11'h001;
    touch = 11'h001;
    settle(3);
    chk("touch as drive", 11'h001, {10'h0, pin[0]});
    link = 11'h000;
    touch = 11'h000;
  endtask

  // Mirror follows polarity writes unless blocked
  task automatic t_mirror();
    logic [1:0] pv;
    wr_reg(8'h75, 8'h80);
    rd_reg(8'h79, rv);
    chk("mirror follow", 11'h080, {3'h0, rv});
    blk = 1'b1;
    wr_reg(8'h75, 8'h01);
    rd_reg(8'h79, rv);
    chk("mirror blocked", 11'h080, {3'h0, rv});
    blk = 1'b0;
    settle(2);
    pv = {oe_n[0], pin[0]};
    wr_reg(8'h79, 8'hFF);
    settle(2);
    chk("mirror pin", {9'h0, pv}, {9'h0, oe_n[0], pin[0]});
    wr_reg(8'h79, 8'h00);
  endtask

  // Touch linking of channels 8 to 11
  task automatic t_link();
    wr_reg(8'h70, 8'h80);
    link = 11'h200;
    touch = 11'h100;
    settle(3);
    chk("grouped link", 11'h006, {8'h0, oe_n[10:8]});
    link = 11'h480;
    touch = 11'h480;
    settle(3);
    chk("unlinkable", 11'h00F, {7'h0, oe_n[10:7]});
    link = 11'h000;
    touch = 11'h000;
  endtask

  // Duty cycle versus polarity on channel 9
  task automatic t_pwm();
    logic [3:0] pb [5] = '{4'h0, 4'h2, 4'h8, 4'hA, 4'h3};
    int         ex [5] = '{40, 140, 160, 60, 100};
    pwm_en = 11'h100;
    for (int c = 0; c < 5; c++) begin
      wr_reg(8'h76, {7'h0, pb[c][3]});
      wr_reg(8'h74, {7'h0, pb[c][1]});
      brth = {2'h0, pb[c][0], 8'h0};
      settle(4);
      n = 0;
      repeat (200) begin
        @(posedge clk);
        #1;
        if (oe_n[8] === 1'b0) n++;
      end
      chk("low cycles", ex[c][10:0], n[10:0]);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n, wr, rd, blk} = 4'h0;
    {addr, wdata, irq_en, clr, ext_val} = '0;
    ext_en = 8'hFF;
    {pwm_en, brth, link, touch} = '0;
    min_d = 7'h14;
    max_d = 7'h46;
    ramp = 7'h32;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_input();
    t_drive();
    t_mirror();
    t_link();
    t_pwm();
    tally_and_finish();
  end
endmodule
